// File: pau_port_upper.sv
// upper pins 5..7 of port A: latch, direction, read path and oscillator takeover
`timescale 1ns/1ps
module pau_port_upper (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register bus
   input wire pau_pkg::pau_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // configuration
   input wire logic osc_pin_mode_cfg,
   input wire pau_pkg::pau_osc_mode_t osc_mode,
   input wire logic cycle_clock_out_en,
   // peripheral functions on pin 5
   input wire pau_pkg::pau_a5_func_t a5_func,
   output logic timer1_clock_in,
   output logic slave_select_in,
   // pads, output enable active low
   input wire logic [7:5] pad_in,
   output logic [7:5] pad_out,
   output logic [7:5] pad_oe_n
);
   import pau_pkg::*;

   logic [7:0] output_latch_a;
   logic [7:0] direction_a;
   logic [7:0] analog_select_0;
   logic [1:0] div_cnt;
   logic cycle_clock;
   logic [7:5] next_pad_out;
   logic [7:5] next_pad_oe_n;
   logic [7:0] next_rdata;
   logic [7:5] pin_read;
   logic clk_mode;

   assign clk_mode = (osc_mode == PAU_OSC_EXT_CLOCK) || (osc_mode == PAU_OSC_INTERNAL);

   // registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         output_latch_a <= RST_LATCH;
         direction_a <= RST_DIRECTION;
         analog_select_0 <= RST_ANALOG_SEL;
      end else if (bus_req.wr) begin
         case (bus_req.addr)
            ADDR_PIN_LEVEL, ADDR_OUT_LATCH: output_latch_a <= bus_req.wdata;
            ADDR_DIRECTION: direction_a <= bus_req.wdata;
            ADDR_ANALOG_SEL: analog_select_0 <= bus_req.wdata;
            default: ;
         endcase
      end
   end

   // cycle clock divider: high for two of four cycles
   always_ff @(posedge clk) begin
      if (!rstn) begin
         div_cnt <= 2'h0;
         cycle_clock <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
         cycle_clock <= (div_cnt >= 2'(CYC_DIV / 2));
      end
   end

   // pad drive
   always_comb begin
      next_pad_out = '0;
      next_pad_oe_n = '1;
      if (a5_func.charge_unit_en) begin
         next_pad_out[BIT_A5] = a5_func.charge_unit_out;
         next_pad_oe_n[BIT_A5] = 1'b0;
      end else if (a5_func.timer1_clock_in_en) begin
         next_pad_oe_n[BIT_A5] = 1'b1;
      end else if (!direction_a[BIT_A5]) begin
         next_pad_out[BIT_A5] = output_latch_a[BIT_A5];
         next_pad_oe_n[BIT_A5] = 1'b0;
      end
      if (osc_pin_mode_cfg) begin
         next_pad_oe_n[BIT_A7] = 1'b1;
         if (clk_mode && cycle_clock_out_en) begin
            next_pad_out[BIT_A6] = cycle_clock;
            next_pad_oe_n[BIT_A6] = 1'b0;
         end
      end else begin
         for (int i = BIT_A6; i <= BIT_A7; i++) begin
            next_pad_out[i] = output_latch_a[i];
            next_pad_oe_n[i] = direction_a[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pad_out <= '0;
         pad_oe_n <= '1;
      end else begin
         pad_out <= next_pad_out;
         pad_oe_n <= next_pad_oe_n;
      end
   end

   // digital read paths
   always_comb begin
      pin_read[BIT_A5] = analog_select_0[BIT_A4] ? 1'b0 : pad_in[BIT_A5];
      pin_read[BIT_A6] = osc_pin_mode_cfg ? UNDEF_BIT : pad_in[BIT_A6];
      pin_read[BIT_A7] = osc_pin_mode_cfg ? UNDEF_BIT : pad_in[BIT_A7];
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         timer1_clock_in <= 1'b0;
         slave_select_in <= 1'b1;
      end else begin
         timer1_clock_in <= pad_in[BIT_A5];
         slave_select_in <= pin_read[BIT_A5];
      end
   end

   // read data
   always_comb begin
      next_rdata = RST_READ;
      case (bus_req.addr)
         ADDR_PIN_LEVEL: next_rdata[7:5] = pin_read;
         ADDR_OUT_LATCH: next_rdata[7:5] = output_latch_a[7:5];
         ADDR_DIRECTION: next_rdata[7:5] = direction_a[7:5];
         ADDR_ANALOG_SEL: next_rdata = analog_select_0;
         default: next_rdata = RST_READ;
      endcase
      if (bus_req.addr != ADDR_ANALOG_SEL) begin
         next_rdata[BIT_A4] = 1'b0;
         if (osc_pin_mode_cfg) begin
            next_rdata[BIT_A6] = UNDEF_BIT;
            next_rdata[BIT_A7] = UNDEF_BIT;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_rdata <= RST_READ;
      end else if (bus_req.rd) begin
         bus_rdata <= next_rdata;
      end else begin
         bus_rdata <= RST_READ;
      end
   end

   AST_A5_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
      (!direction_a[BIT_A5] && !a5_func.charge_unit_en && !a5_func.timer1_clock_in_en)
      |=> (!pad_oe_n[BIT_A5] && pad_out[BIT_A5] == $past(output_latch_a[BIT_A5])))
      else $error("pin 5 not driving latch");
   AST_A5_ANALOG: assert property (@(posedge clk) disable iff (!rstn)
      (bus_req.rd && bus_req.addr == ADDR_PIN_LEVEL && analog_select_0[BIT_A4])
      |=> !bus_rdata[BIT_A5]) else $error("pin 5 read while analog");
   AST_RESET_ANALOG: assert property (@(posedge clk)
      $rose(rstn) |-> analog_select_0[BIT_A4]) else $error("pin 5 not analog");
   AST_OSC_NO_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
      osc_pin_mode_cfg ##1 osc_pin_mode_cfg |-> pad_oe_n[BIT_A7])
      else $error("pin 7 driven in osc mode");
   sequence s_cfg_read;
      osc_pin_mode_cfg && bus_req.rd && bus_req.addr == ADDR_PIN_LEVEL;
   endsequence
   AST_OSC_NO_READ: assert property (@(posedge clk) disable iff (!rstn)
      s_cfg_read |=> bus_rdata[7:6] == {2{UNDEF_BIT}}) else $error("osc pins read");
   AST_CYCLE_CLOCK_OUT: assert property (@(posedge clk) disable iff (!rstn)
      (osc_pin_mode_cfg && clk_mode && cycle_clock_out_en)[*2] |-> !pad_oe_n[BIT_A6])
      else $error("cycle clock not driven");
   AST_BIT4_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr != ADDR_ANALOG_SEL |=> !bus_rdata[BIT_A4])
      else $error("bit 4 nonzero");
   AST_T1_OVERRIDE: assert property (@(posedge clk) disable iff (!rstn)
      a5_func.timer1_clock_in_en && !a5_func.charge_unit_en |=> pad_oe_n[BIT_A5])
      else $error("pin 5 driven as timer input");
   AST_LATCH_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == ADDR_PIN_LEVEL |=> output_latch_a == $past(bus_req.wdata))
      else $error("pin write missed latch");

   // register updates and idle read data
   AST_OUT_LATCH_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == ADDR_OUT_LATCH |=> output_latch_a == $past(bus_req.wdata))
      else $error("latch write missed");
   AST_DIR_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == ADDR_DIRECTION |=> direction_a == $past(bus_req.wdata))
      else $error("direction write missed");
   AST_ANALOG_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == ADDR_ANALOG_SEL
      |=> analog_select_0 == $past(bus_req.wdata))
      else $error("analog select write missed");
   AST_PIN_WRITE_KEEPS_DIR: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == ADDR_PIN_LEVEL |=> direction_a == $past(direction_a))
      else $error("pin write changed direction");
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      !bus_req.rd |=> bus_rdata == RST_READ)
      else $error("read data outside read slot");

   // read paths
   AST_RD_LATCH: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == ADDR_OUT_LATCH && !osc_pin_mode_cfg
      |=> bus_rdata[7:5] == $past(output_latch_a[7:5]))
      else $error("latch read wrong");
   AST_RD_DIR: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == ADDR_DIRECTION && !osc_pin_mode_cfg
      |=> bus_rdata[7:5] == $past(direction_a[7:5]))
      else $error("direction read wrong");
   AST_RD_ANALOG: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == ADDR_ANALOG_SEL |=> bus_rdata == $past(analog_select_0))
      else $error("analog select read wrong");
   AST_A5_DIGITAL_READ: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == ADDR_PIN_LEVEL && !analog_select_0[BIT_A4]
      |=> bus_rdata[BIT_A5] == $past(pad_in[BIT_A5]))
      else $error("pin 5 digital read wrong");
   AST_LOW_BITS_ZERO: assert property (@(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr != ADDR_ANALOG_SEL |=> bus_rdata[3:0] == 4'h0)
      else $error("low bits nonzero");
   AST_OSC_LATCH_READ: assert property (@(posedge clk) disable iff (!rstn)
      osc_pin_mode_cfg && bus_req.rd && bus_req.addr == ADDR_OUT_LATCH
      |=> bus_rdata[7:6] == {2{UNDEF_BIT}})
      else $error("osc pins latch read");
   AST_OSC_DIR_READ: assert property (@(posedge clk) disable iff (!rstn)
      osc_pin_mode_cfg && bus_req.rd && bus_req.addr == ADDR_DIRECTION
      |=> bus_rdata[7:6] == {2{UNDEF_BIT}})
      else $error("osc pins direction read");

   // pin 5 drive and peripheral inputs
   AST_A5_INPUT: assert property (@(posedge clk) disable iff (!rstn)
      direction_a[BIT_A5] && !a5_func.charge_unit_en |=> pad_oe_n[BIT_A5])
      else $error("pin 5 driven as input");
   AST_A5_CHARGE: assert property (@(posedge clk) disable iff (!rstn)
      a5_func.charge_unit_en
      |=> !pad_oe_n[BIT_A5] && pad_out[BIT_A5] == $past(a5_func.charge_unit_out))
      else $error("charge unit output missing");
   AST_T1_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> timer1_clock_in == $past(pad_in[BIT_A5]))
      else $error("timer input not following pad");
   AST_SS_ANALOG: assert property (@(posedge clk) disable iff (!rstn)
      analog_select_0[BIT_A4] |=> !slave_select_in)
      else $error("slave select read while analog");
   AST_SS_DIGITAL: assert property (@(posedge clk) disable iff (!rstn)
      !analog_select_0[BIT_A4] |=> slave_select_in == $past(pad_in[BIT_A5]))
      else $error("slave select not following pad");

   // pins 6 and 7 as port pins or oscillator pins
   AST_A6_PORT: assert property (@(posedge clk) disable iff (!rstn)
      !osc_pin_mode_cfg |=> pad_oe_n[BIT_A6] == $past(direction_a[BIT_A6])
         && pad_out[BIT_A6] == $past(output_latch_a[BIT_A6]))
      else $error("pin 6 port drive wrong");
   AST_A7_PORT: assert property (@(posedge clk) disable iff (!rstn)
      !osc_pin_mode_cfg |=> pad_oe_n[BIT_A7] == $past(direction_a[BIT_A7])
         && pad_out[BIT_A7] == $past(output_latch_a[BIT_A7]))
      else $error("pin 7 port drive wrong");
   AST_OSC_A6_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      osc_pin_mode_cfg && !(clk_mode && cycle_clock_out_en) |=> pad_oe_n[BIT_A6])
      else $error("pin 6 driven in osc mode");
   AST_CYCLE_CLOCK_OUT_CRYSTAL: assert property (@(posedge clk) disable iff (!rstn)
      osc_pin_mode_cfg && osc_mode == PAU_OSC_CRYSTAL |=> pad_oe_n[BIT_A6])
      else $error("cycle clock in crystal mode");

   // cycle clock shape: two high, two low
   sequence s_cyc_rise;
      !cycle_clock ##1 cycle_clock;
   endsequence
   sequence s_cyc_fall;
      cycle_clock ##1 !cycle_clock;
   endsequence
   sequence s_cycle_clock_out_on;
      osc_pin_mode_cfg && clk_mode && cycle_clock_out_en;
   endsequence
   AST_CYCLE_HIGH: assert property (@(posedge clk) disable iff (!rstn)
      s_cyc_rise |=> cycle_clock ##1 !cycle_clock)
      else $error("cycle clock high phase wrong");
   AST_CYCLE_LOW: assert property (@(posedge clk) disable iff (!rstn)
      s_cyc_fall |=> !cycle_clock ##1 cycle_clock)
      else $error("cycle clock low phase wrong");
   AST_CYCLE_CLOCK_OUT_FOLLOW: assert property (@(posedge clk) disable iff (!rstn)
      s_cycle_clock_out_on |=> !pad_oe_n[BIT_A6] && pad_out[BIT_A6] == $past(cycle_clock))
      else $error("pin 6 not showing cycle clock");

   // reset state
   AST_RESET_PADS: assert property (@(posedge clk)
      !rstn |=> pad_oe_n == 3'b111 && pad_out == 3'b000)
      else $error("pads not released in reset");
   AST_RESET_REGS: assert property (@(posedge clk)
      !rstn |=> direction_a == RST_DIRECTION && analog_select_0 == RST_ANALOG_SEL)
      else $error("registers not reset");
   AST_RESET_RDATA: assert property (@(posedge clk)
      !rstn |=> bus_rdata == RST_READ)
      else $error("read data not reset");
endmodule

// File: pau_pkg.sv
// package for the port A upper pin control block
package pau_pkg;
   localparam logic [1:0] ADDR_PIN_LEVEL = 2'h0;
   localparam logic [1:0] ADDR_OUT_LATCH = 2'h1;
   localparam logic [1:0] ADDR_DIRECTION = 2'h2;
   localparam logic [1:0] ADDR_ANALOG_SEL = 2'h3;
   localparam int BIT_A4 = 4;
   localparam int BIT_A5 = 5;
   localparam int BIT_A6 = 6;
   localparam int BIT_A7 = 7;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hff;
   localparam logic [7:0] RST_ANALOG_SEL = 8'hff;
   // value returned for the unimplemented and disabled bits
   localparam logic [7:0] RST_READ = 8'h00;
   localparam logic UNDEF_BIT = 1'b0;
   localparam int CYC_DIV = 4;
   // oscillator mode straps
   typedef enum logic [1:0] {
      PAU_OSC_CRYSTAL = 2'b00,
      PAU_OSC_EXT_CLOCK = 2'b01,
      PAU_OSC_INTERNAL = 2'b10,
      PAU_OSC_RSVD = 2'b11
   } pau_osc_mode_t;
   // register bus request
   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pau_bus_req_t;
   // peripheral function selects on pin a5
   typedef struct packed {
      logic timer1_clock_in_en;
      logic charge_unit_en;
      logic charge_unit_out;
   } pau_a5_func_t;
endpackage

// File: pau_pad_model.sv
// pad model: each pad shows the design drive or the outside level
`timescale 1ns/1ps
module pau_pad_model (
   // design side
   input wire logic [7:5] pad_out,
   input wire logic [7:5] pad_oe_n,
   // outside world
   input wire logic [7:5] ext_lvl,
   output logic [7:5] pad_in
);
   // a driving design wins over the outside level
   always_comb begin
      for (int i = 5; i < 8; i++) begin
         pad_in[i] = pad_oe_n[i] ? ext_lvl[i] : pad_out[i];
      end
   end
endmodule

// File: pau_port_upper_tb_top.sv
// testbench for the port A upper pin control block
`timescale 1ns/1ps
module pau_port_upper_tb_top;
   import pau_pkg::*;
   logic clk, rstn, cfg, ccen, p, t1in, ssin;
   pau_bus_req_t req;
   pau_osc_mode_t mode;
   pau_a5_func_t fn;
   logic [7:0] rdata;
   logic [7:5] pin, pout, poe_n, ext;
   int fails, compares, n;
   pau_port_upper pau_port_upper_i (.clk(clk), .rstn(rstn), .bus_req(req),
      .bus_rdata(rdata), .osc_pin_mode_cfg(cfg), .osc_mode(mode),
      .cycle_clock_out_en(ccen), .a5_func(fn), .timer1_clock_in(t1in),
      .slave_select_in(ssin), .pad_in(pin), .pad_out(pout), .pad_oe_n(poe_n));
   pau_pad_model pau_pad_model_i (.pad_out(pout), .pad_oe_n(poe_n), .ext_lvl(ext),
      .pad_in(pin));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // each access stands one cycle, then the bus idles one cycle
   task automatic acc(logic [1:0] a, logic [7:0] d, logic w);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(logic [1:0] a, logic [7:0] exp);
      acc(a, 8'h00, 1'b0);
      #1 chk("bus_rdata", exp, rdata);
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      req = '0;
      cfg = 1'b0;
      ccen = 1'b0;
      mode = PAU_OSC_CRYSTAL;
      fn = '0;
      ext = 3'h0;
      cyc(20);
      chk("pad_oe_n", 8'h07, {5'h0, poe_n});
      @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_DIRECTION, 8'he0);
      rd(ADDR_ANALOG_SEL, RST_ANALOG_SEL);
      acc(ADDR_OUT_LATCH, 8'hff, 1'b1);
      acc(ADDR_DIRECTION, 8'h00, 1'b1);
      cyc(3);
      chk("pad_out", 8'h07, {5'h0, pout});
      chk("pad_oe_n", 8'h00, {5'h0, poe_n});
      rd(ADDR_OUT_LATCH, 8'he0);
      rd(ADDR_PIN_LEVEL, 8'hc0);
      acc(ADDR_ANALOG_SEL, 8'h00, 1'b1);
      rd(ADDR_PIN_LEVEL, 8'he0);
      acc(ADDR_PIN_LEVEL, 8'h00, 1'b1);
      rd(ADDR_OUT_LATCH, 8'h00);
      $display("test latch and direction done");
      acc(ADDR_DIRECTION, 8'hff, 1'b1);
      ext <= 3'b101;
      cyc(3);
      rd(ADDR_PIN_LEVEL, 8'ha0);
      chk("slave_select_in", 8'h01, {7'h0, ssin});
      fn <= '{timer1_clock_in_en: 1'b0, charge_unit_en: 1'b1, charge_unit_out: 1'b1};
      cyc(3);
      chk("pad5", 8'h02, {6'h0, pout[5], poe_n[5]});
      chk("timer1_clock_in", 8'h01, {7'h0, t1in});
      fn <= '0;
      cfg <= 1'b1;
      ext <= 3'b111;
      acc(ADDR_DIRECTION, 8'h00, 1'b1);
      cyc(3);
      chk("pad_oe_n", 8'h06, {5'h0, poe_n});
      rd(ADDR_PIN_LEVEL, {UNDEF_BIT, UNDEF_BIT, 6'h00});
      acc(ADDR_DIRECTION, 8'hff, 1'b1);
      for (int m = 1; m < 3; m++) begin
         mode <= pau_osc_mode_t'(m);
         ccen <= 1'b1;
         cyc(4);
         n = 0;
         repeat (16) begin
            p = pout[6];
            cyc(1);
            n += (pout[6] === 1'b1 && p === 1'b0);
         end
         chk("clock_rises", 8'(16 / CYC_DIV), 8'(n));
         chk("pad_oe_n", 8'h05, {5'h0, poe_n});
      end
      mode <= PAU_OSC_CRYSTAL;
      cyc(4);
      chk("pad_oe_n", 8'h07, {5'h0, poe_n});
      $display("test oscillator takeover done");
      stop_test();
   end
endmodule
